// ==== rtl/flow_port_map.svh ====
// Constants of the flow sensor two-wire read port.
// Assumes inclusion by the port package and the port module only.
`ifndef FLOW_PORT_MAP_SVH
`define FLOW_PORT_MAP_SVH

`define FLOW_TARGET_ADDR 7'h50
`define FLOW_READ_BIT 1'b1
`define FLOW_BITS_PER_BYTE 4'h8
`define FLOW_LAST_BIT 3'h7
`define FLOW_LAST_BYTE 3'h4
`define FLOW_COUNT_WIDTH 12
`define FLOW_HIGH_PAD 4'h0
`define FLOW_RESET_COUNT 12'h000

`endif

// ==== rtl/flow_port_pkg.sv ====
// Types shared by the flow sensor two-wire read port.
// Assumes the constants header is compiled alongside.
`include "flow_port_map.svh"

package flow_port_pkg;

	typedef enum logic [2:0]
	{
		IDLE = 3'h0,
		ADDR = 3'h1,
		ADDR_ACK = 3'h3,
		TX = 3'h2,
		TX_ACK = 3'h6
	} state_t;

	typedef struct packed
	{
		logic scl;
		logic sda;
	} pins_t;

	typedef struct packed
	{
		logic [`FLOW_COUNT_WIDTH-1:0] count;
	} flow_t;

endpackage

// ==== rtl/flow_sensor_i2c_read_port.sv ====
// Two-wire target port that returns checksum and flow count on a read.
// Assumes external pull-ups on both lines and a measurement source that
// delivers samples on its own clock with a one-cycle valid strobe.
// Behaviour
// R01: Answer only address 50 hex, ignore others.
// R02: Data falling while clock high starts transfer.
// R03: Data rising while clock high ends transfer.
// R04: Eight data bits then one response bit.
// R05: Pull data low to acknowledge, then release.
// R06: Master treats undriven response as not-acknowledge.
// R07: After acknowledge master continues or stops.
// R08: Sample on rising clock, hold while high.
// R09: Latest flow sample always ready for reads. The code ignores a sample that arrives before the previous one is acknowledged.
// R10: Transmit each byte most significant bit first.
// R11: Master sends address with read bit set.
// R12: Checksum byte first, then two flow bytes.
// R13: Twelve-bit count, high byte upper nibble zero.
// R14: Checksum is negated byte sum of data.
// R15: Master accepts payload when sum is zero.
// R16: Frame of five bytes, flow bytes repeated.
// R17: Works at 100 kHz and 400 kHz.
// R18: Lines only pulled low or released.
// R19: Master not-acknowledges final byte before stop.
`timescale 1ns/1ps
`include "flow_port_map.svh"

module flow_sensor_i2c_read_port
(
	// System clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Measurement domain.
	input wire logic measClk,
	input wire logic measValid,
	input wire flow_port_pkg::flow_t measData,
	// Two-wire bus pins.
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// Status.
	output logic selected
);

	// Measurement side holds a sample and toggles a request.
	flow_port_pkg::flow_t holdData, next_holdData;
	logic reqTgl, next_reqTgl;
	logic ackM1, ackM2;
	logic ackTgl, next_ackTgl;
	logic reqS1, reqS2, reqS3;
	flow_port_pkg::flow_t flowNow, next_flowNow;

	always_comb
	begin
		next_holdData = holdData;
		next_reqTgl = reqTgl;
		if (measValid && (reqTgl == ackM2))
		begin
			next_holdData = measData; // see R09
			next_reqTgl = ~reqTgl;
		end
	end

	always_ff @(posedge measClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			holdData <= '0;
			reqTgl <= 1'b0;
			ackM1 <= 1'b0;
			ackM2 <= 1'b0;
		end
		else
		begin
			holdData <= next_holdData;
			reqTgl <= next_reqTgl;
			ackM1 <= ackTgl;
			ackM2 <= ackM1;
		end
	end

	// The held sample is stable until the acknowledge returns.
	always_comb
	begin
		next_flowNow = flowNow;
		next_ackTgl = ackTgl;
		if (reqS3 != reqS2)
		begin
			next_flowNow = holdData; // see R09
			next_ackTgl = reqS2;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reqS1 <= 1'b0;
			reqS2 <= 1'b0;
			reqS3 <= 1'b0;
			flowNow <= '{count: `FLOW_RESET_COUNT};
			ackTgl <= 1'b0;
		end
		else
		begin
			reqS1 <= reqTgl;
			reqS2 <= reqS1;
			reqS3 <= reqS2;
			flowNow <= next_flowNow;
			ackTgl <= next_ackTgl;
		end
	end

	// Pin filter: a level is taken once stages two and three agree.
	flow_port_pkg::pins_t pinS1, pinS2, pinS3;
	flow_port_pkg::pins_t pinLvl, next_pinLvl, pinPrev;

	always_comb
	begin
		next_pinLvl = pinLvl;
		if (pinS2.scl == pinS3.scl)
			next_pinLvl.scl = pinS3.scl;
		if (pinS2.sda == pinS3.sda)
			next_pinLvl.sda = pinS3.sda;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pinS1 <= '{scl: 1'b1, sda: 1'b1};
			pinS2 <= '{scl: 1'b1, sda: 1'b1};
			pinS3 <= '{scl: 1'b1, sda: 1'b1};
			pinLvl <= '{scl: 1'b1, sda: 1'b1};
			pinPrev <= '{scl: 1'b1, sda: 1'b1};
		end
		else
		begin
			pinS1 <= '{scl: sclIn, sda: sdaIn}; // see R17
			pinS2 <= pinS1;
			pinS3 <= pinS2;
			pinLvl <= next_pinLvl;
			pinPrev <= pinLvl;
		end
	end

	logic sclRise, sclFall, startSeen, stopSeen;

	always_comb
	begin
		sclRise = pinLvl.scl && !pinPrev.scl; // see R08
		sclFall = !pinLvl.scl && pinPrev.scl;
		startSeen = pinLvl.scl && pinPrev.scl && pinPrev.sda
			&& !pinLvl.sda; // see R02
		stopSeen = pinLvl.scl && pinPrev.scl && !pinPrev.sda
			&& pinLvl.sda; // see R03
	end

	// Frame builder: checksum, high, low, high, low.
	function automatic logic [7:0] frameByte(input logic [2:0] idx,
		input logic [`FLOW_COUNT_WIDTH-1:0] cnt);
		logic [7:0] hi;
		logic [7:0] lo;
		logic [7:0] sum;
		hi = {`FLOW_HIGH_PAD, cnt[11:8]}; // see R13
		lo = cnt[7:0];
		sum = 8'(hi + lo + hi + lo); // see R16
		case (idx)
			3'h0: frameByte = 8'(~sum + 8'h01); // see R14, R12
			3'h1, 3'h3: frameByte = hi;
			default: frameByte = lo;
		endcase
	endfunction

	// Protocol engine.
	flow_port_pkg::state_t state, next_state;
	logic [3:0] bitCnt, next_bitCnt;
	logic [7:0] shiftReg, next_shiftReg;
	logic [2:0] byteIdx, next_byteIdx;
	logic [`FLOW_COUNT_WIDTH-1:0] snap, next_snap;
	logic masterAck, next_masterAck;
	logic next_sdaOe, next_selected;

	always_comb
	begin
		next_state = state;
		next_bitCnt = bitCnt;
		next_shiftReg = shiftReg;
		next_byteIdx = byteIdx;
		next_snap = snap;
		next_masterAck = masterAck;
		next_sdaOe = sdaOe;
		if (stopSeen)
		begin
			next_state = flow_port_pkg::IDLE; // see R03
			next_sdaOe = 1'b0;
		end
		else if (startSeen)
		begin
			next_state = flow_port_pkg::ADDR; // see R02
			next_bitCnt = 4'h0;
			next_sdaOe = 1'b0;
			next_snap = flowNow.count; // see R09
		end
		else
		begin
			case (state)
				flow_port_pkg::IDLE:
					next_sdaOe = 1'b0;
				flow_port_pkg::ADDR:
				begin
					if (sclRise)
					begin
						next_shiftReg = {shiftReg[6:0], pinLvl.sda};
						next_bitCnt = 4'(bitCnt + 4'h1); // see R04
					end
					else if (sclFall && bitCnt == `FLOW_BITS_PER_BYTE)
					begin
						if (shiftReg[7:1] == `FLOW_TARGET_ADDR
							&& shiftReg[0] == `FLOW_READ_BIT)
						begin
							next_state = flow_port_pkg::ADDR_ACK;
							next_sdaOe = 1'b1; // see R05, R01
						end
						else
							next_state = flow_port_pkg::IDLE; // see R01
					end
				end
				flow_port_pkg::ADDR_ACK:
				begin
					if (sclFall)
					begin
						next_byteIdx = 3'h0;
						next_shiftReg = frameByte(3'h0, snap); // see R12
						next_sdaOe = ~next_shiftReg[7]; // see R10
						next_bitCnt = 4'h0;
						next_state = flow_port_pkg::TX;
					end
				end
				flow_port_pkg::TX:
				begin
					if (sclFall)
					begin
						if (bitCnt[2:0] == `FLOW_LAST_BIT)
						begin
							next_sdaOe = 1'b0; // see R05, R04
							next_state = flow_port_pkg::TX_ACK;
						end
						else
						begin
							next_bitCnt = 4'(bitCnt + 4'h1);
							next_shiftReg = {shiftReg[6:0], 1'b0};
							next_sdaOe = ~shiftReg[6]; // see R10, R18
						end
					end
				end
				flow_port_pkg::TX_ACK:
				begin
					if (sclRise)
						next_masterAck = !pinLvl.sda; // see R04
					else if (sclFall)
					begin
						if (masterAck && byteIdx != `FLOW_LAST_BYTE)
						begin
							next_byteIdx = 3'(byteIdx + 3'h1);
							next_shiftReg = frameByte(next_byteIdx, snap);
							next_sdaOe = ~next_shiftReg[7];
							next_bitCnt = 4'h0;
							next_state = flow_port_pkg::TX; // see R16
						end
						else
							next_state = flow_port_pkg::IDLE;
					end
				end
				default:
				begin
					next_state = flow_port_pkg::IDLE;
					next_sdaOe = 1'b0;
				end
			endcase
		end
		next_selected = (next_state != flow_port_pkg::IDLE)
			&& (next_state != flow_port_pkg::ADDR);
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= flow_port_pkg::IDLE;
			bitCnt <= 4'h0;
			shiftReg <= 8'h00;
			byteIdx <= 3'h0;
			snap <= `FLOW_RESET_COUNT;
			masterAck <= 1'b0;
			sdaOe <= 1'b0;
			sdaOut <= 1'b0;
			selected <= 1'b0;
		end
		else
		begin
			state <= next_state;
			bitCnt <= next_bitCnt;
			shiftReg <= next_shiftReg;
			byteIdx <= next_byteIdx;
			snap <= next_snap;
			masterAck <= next_masterAck;
			sdaOe <= next_sdaOe;
			sdaOut <= 1'b0; // see R18
			selected <= next_selected;
		end
	end

endmodule // flow_sensor_i2c_read_port

// ==== tb/bus_master.sv ====
// Bus master model that frames reads on the two lines.
// Assumes pull-ups; the target only pulls data low.
`timescale 1ns/1ps
module bus_master
(
	// Clock.
	input wire logic clk,
	// Target data drive.
	input wire logic sdaOe,
	// Bus lines.
	output logic scl,
	output wire logic sda
);
	logic sdaRel;
	int lowTime = 15;
	int highTime = 12;
	initial sdaRel = 1'b1;
	initial scl = 1'b1;
	assign sda = sdaRel & ~sdaOe;
	task w(input int n);
		repeat (n) @(posedge clk);
	endtask
	task start;
		w(7);
		sdaRel <= 1'b1;
		w(8);
		scl <= 1'b1;
		w(8);
		sdaRel <= 1'b0;
		w(8);
		scl <= 1'b0;
	endtask
	task stop;
		w(7);
		sdaRel <= 1'b0;
		w(8);
		scl <= 1'b1;
		w(8);
		sdaRel <= 1'b1;
		w(8);
	endtask
	task xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
		begin
			w(7);
			sdaRel <= tx[i];
			w(lowTime - 7);
			scl <= 1'b1;
			w(highTime);
			rx[i] = sda;
			scl <= 1'b0;
		end
	endtask
endmodule // bus_master

// ==== tb/port_chk.sv ====
// Assertions on the flow port pins.
// Assumes a bind onto the port module.
`timescale 1ns/1ps
module port_chk
(
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Pins.
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic selected
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence startSeq;
		sclIn && $fell(sdaIn);
	endsequence
	sequence stopSeq;
		sclIn && $rose(sdaIn);
	endsequence
	sequence ackSeq;
		sdaOe [*8];
	endsequence
	a_out_low: assert property (!sdaOut)
		else $error("sdaOut high");
	a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
		else $error("drive moved, clock high");
	a_oe_hold: assert property ($fell(sclIn) |-> $stable(sdaOe) [*3])
		else $error("drive moved early");
	a_ack_drive: assert property ($rose(selected) |-> ackSeq)
		else $error("ack too short");
	a_drive_sel: assert property ($rose(sdaOe) |-> selected)
		else $error("drive unselected");
	a_stop_free: assert property (stopSeq |-> ##[1:8] !selected)
		else $error("stop ignored");
	a_start_free: assert property (startSeq |-> ##[1:8] !selected)
		else $error("start ignored");
	a_end_free: assert property ($fell(selected) |-> !sdaOe)
		else $error("drive after end");
endmodule // port_chk

bind flow_sensor_i2c_read_port port_chk port_chk_inst
(
	.clk(clk), .arst_n(arst_n), .sclIn(sclIn), .sdaIn(sdaIn),
	.sdaOut(sdaOut), .sdaOe(sdaOe), .selected(selected)
);

// ==== tb/testbench.sv ====
// Testbench of the flow port: reads, refusals and early ends.
// Assumes the master model drives the bus lines.
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic measClk = 1'b0;
	logic arst_n = 1'b0;
	logic measValid = 1'b0;
	flow_port_pkg::flow_t measData = '0;
	logic scl;
	wire sda;
	logic sdaOut;
	logic sdaOe;
	logic selected;
	int n_mismatch = 0;
	int check_count = 0;
	always #2.5 clk = ~clk;
	always #24 measClk = ~measClk;
	flow_sensor_i2c_read_port flow_sensor_i2c_read_port_inst
	(
		.clk(clk), .arst_n(arst_n), .measClk(measClk), .measValid(measValid),
		.measData(measData), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .selected(selected)
	);
	bus_master bus_master_inst
	(
		.clk(clk), .sdaOe(sdaOe), .scl(scl), .sda(sda)
	);
	task summarize;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task cmp(input string nm, input logic [8:0] e, input logic [8:0] g);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task load(input logic [11:0] c);
		@(posedge measClk);
		measValid <= 1'b1;
		measData.count <= c;
		@(posedge measClk);
		measValid <= 1'b0;
		repeat (20) @(posedge clk);
	endtask
	task do_read(input logic [11:0] c, input int n);
		logic [8:0] rx;
		logic [7:0] f [6];
		f[1] = {4'h0, c[11:8]};
		f[2] = c[7:0];
		f[3] = f[1];
		f[4] = f[2];
		f[0] = 8'h00 - f[1] - f[2] - f[3] - f[4];
		f[5] = 8'hff;
		load(c);
		bus_master_inst.start();
		bus_master_inst.xfer({7'h50, 1'b1, 1'b1}, rx);
		cmp("ack", 9'h0, {8'h0, rx[0]});
		cmp("sel", 9'h1, {8'h0, selected});
		for (int i = 0; i < n; i++)
		begin
			bus_master_inst.xfer({8'hff, i == n - 1}, rx);
			cmp("byte", {1'b0, f[i]}, {1'b0, rx[8:1]});
		end
		bus_master_inst.stop();
		cmp("free", 9'h0, {6'h0, sdaOut, selected, sdaOe});
	endtask
	task rate_read(input int half, input logic [11:0] c, input int n);
		bus_master_inst.lowTime = half;
		bus_master_inst.highTime = half;
		do_read(c, n);
		bus_master_inst.lowTime = 15;
		bus_master_inst.highTime = 12;
	endtask
	// A count of fff gives a checksum with its top bit high, so the line
	// is free for the STOP right after the address acknowledge.
	task cut_read;
		logic [8:0] rx;
		load(12'hfff);
		bus_master_inst.start();
		bus_master_inst.xfer({7'h50, 1'b1, 1'b1}, rx);
		cmp("ack", 9'h0, {8'h0, rx[0]});
		cmp("sel", 9'h1, {8'h0, selected});
		bus_master_inst.stop();
		cmp("cut", 9'h0, {7'h0, selected, sdaOe});
	endtask
	task refuse(input logic [7:0] a);
		logic [8:0] rx;
		bus_master_inst.start();
		bus_master_inst.xfer({a, 1'b1}, rx);
		cmp("nack", 9'h1, {8'h0, rx[0]});
		cmp("idle", 9'h0, {8'h0, selected});
		bus_master_inst.stop();
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge clk);
		do_read(12'h199, 5);
		do_read(12'hfff, 6);
		do_read(12'h0a5, 2);
		refuse(8'ha3);
		refuse(8'ha0);
		refuse(8'h51);
		cut_read();
		rate_read(250, 12'h3c7, 2);
		rate_read(1000, 12'h812, 1);
		summarize();
	end
	initial
	begin
		#400000;
		n_mismatch++;
		summarize();
	end
endmodule // testbench
